// file: dswc_dev.sv
// converter end: serial word capture, code register and power mode
//
// How it works
// - frame low starts, sample data on sclk fall
// - sixteenth fall executes word immediately
// - frame may stay low or rise after
// - host holds frame high 33 ns between writes
// - host may park frame low between writes
// - host serial clock at most 30 MHz
// - msb first; 15:14 ignored, mode, code
// - code bits load on sixteenth fall
// - early frame rise discards the word
// - code register clears at power up
// - mode 00 normal,01 1k,10 100k,11 hiz
// - power down keeps code, switches termination
// - host waits before trusting output after wake
`timescale 1ns/10ps
module dswc_dev
  import dswc_pkg::*;
(
  input  wire logic        clk_sys_i,     // system clock
  input  wire logic        rstn_i,        // power-on reset, sync, low
  dswc_if.dev              link,          // serial pins
  output logic [11:0]      code_o,        // converter code register
  output logic [1:0]       mode_o,        // power mode field
  output logic             amp_on_o,      // amplifier and linear circuitry on
  output logic             term_1k_o,     // 1k termination to ground
  output logic             term_100k_o,   // 100k termination to ground
  output logic             update_o       // pulse: word executed
);
  logic [1:0]  sync_meta_reg;
  logic [1:0]  sclk_meta_reg;
  logic [1:0]  sdata_meta_reg;
  logic        sync_prev_reg;
  logic        sclk_prev_reg;
  logic [15:0] shift_reg;
  logic [4:0]  cnt_reg;
  logic        armed_reg;
  logic        sync_low;
  logic        sync_fall;
  logic        sclk_fall;
  logic        frame_clear;
  logic        bit_take;
  logic        exec_now;
  logic [15:0] word_next;

  // count at which the next fall completes the word
  function automatic logic dswc_last_bit(input logic [4:0] cnt);
    return cnt == LAST_BIT_CNT - 5'h1;
  endfunction : dswc_last_bit

  // two-flop synchronisers; stage 0 is read only by stage 1
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      sync_meta_reg <= 2'h0;
    end else begin
      sync_meta_reg <= {sync_meta_reg[0], link.sync_n};
    end
  end

  // each link level must last two samples; a full-rate host is too fast
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      sclk_meta_reg <= 2'h0;
    end else begin
      sclk_meta_reg <= {sclk_meta_reg[0], link.sclk};
    end
  end

  // same depth as the clock path, so a bit lines up with its fall
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      sdata_meta_reg <= 2'h0;
    end else begin
      sdata_meta_reg <= {sdata_meta_reg[0], link.sdata};
    end
  end

  // reset low: a frame already low at release is no fresh fall
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      sync_prev_reg <= 1'b0;
    end else begin
      sync_prev_reg <= sync_meta_reg[1];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      sclk_prev_reg <= 1'b0;
    end else begin
      sclk_prev_reg <= sclk_meta_reg[1];
    end
  end

  assign sync_low    = !sync_meta_reg[1];
  assign sync_fall   = sync_prev_reg && !sync_meta_reg[1];
  assign sclk_fall   = sclk_prev_reg && !sclk_meta_reg[1];
  assign frame_clear = !sync_low || sync_fall;
  assign bit_take    = !frame_clear && sclk_fall && armed_reg;
  assign exec_now    = bit_take && dswc_last_bit(cnt_reg);
  assign word_next   = {shift_reg[14:0], sdata_meta_reg[1]};

  // armed from frame fall until the word executes or the frame aborts
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      armed_reg <= 1'b0;
    end else if (!sync_low) begin
      armed_reg <= 1'b0;
    end else if (sync_fall) begin
      armed_reg <= 1'b1;
    end else if (exec_now) begin
      armed_reg <= 1'b0;
    end
  end

  // stops at sixteen, as later falls are ignored until a new frame
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      cnt_reg <= 5'h00;
    end else if (frame_clear) begin
      cnt_reg <= 5'h00;
    end else if (bit_take) begin
      cnt_reg <= cnt_reg + 5'h01;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      shift_reg <= 16'h0000;
    end else if (frame_clear) begin
      shift_reg <= 16'h0000;
    end else if (bit_take) begin
      shift_reg <= word_next;
    end
  end

  // executes on the sixteenth fall, in the same sample as the last bit
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      code_o <= CODE_RESET;
    end else if (exec_now) begin
      code_o <= word_next[CODE_MSB_POS:0];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      mode_o <= MODE_RESET;
    end else if (exec_now) begin
      mode_o <= word_next[MODE_HI_POS:MODE_LO_POS];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      update_o <= 1'b0;
    end else begin
      update_o <= exec_now;
    end
  end

  // termination follows the stored mode, one cycle behind; code untouched
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      amp_on_o <= 1'b1;
    end else begin
      amp_on_o <= !dswc_is_pd(mode_o);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      term_1k_o <= 1'b0;
    end else begin
      term_1k_o <= mode_o == DSWC_MODE_PD_1K;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      term_100k_o <= 1'b0;
    end else begin
      term_100k_o <= mode_o == DSWC_MODE_PD_100K;
    end
  end
endmodule : dswc_dev

// file: dswc_pkg.sv
// shared constants and types for the serial converter write link
package dswc_pkg;
  localparam int unsigned WORD_BITS      = 16;
  localparam int unsigned CODE_BITS      = 12;
  localparam int unsigned MODE_HI_POS    = 13;
  localparam int unsigned MODE_LO_POS    = 12;
  localparam int unsigned CODE_MSB_POS   = 11;
  localparam logic [11:0] CODE_RESET     = 12'h000;
  localparam logic [1:0]  MODE_RESET     = 2'h0;
  localparam logic [4:0]  LAST_BIT_CNT   = 5'h10;
  // host timing, derived from the 100 MHz system clock
  localparam int unsigned SYS_CLK_MHZ    = 100;
  localparam int unsigned SYNC_HIGH_NS   = 33;
  localparam int unsigned SYNC_HIGH_CYC  = (SYNC_HIGH_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int unsigned SCLK_MAX_MHZ   = 30;
  // half period in system clocks; rounds up so the serial clock stays at or below the limit
  localparam int unsigned SCLK_HALF_CYC  = (SYS_CLK_MHZ + 2 * SCLK_MAX_MHZ - 1) / (2 * SCLK_MAX_MHZ);
  localparam logic [3:0]  SYNC_HIGH_CNT  = 4'(SYNC_HIGH_CYC);
  localparam logic [3:0]  SCLK_HALF_CNT  = 4'(SCLK_HALF_CYC);

  typedef enum logic [1:0] {
    DSWC_MODE_NORMAL = 2'h0,
    DSWC_MODE_PD_1K  = 2'h1,
    DSWC_MODE_PD_100K= 2'h2,
    DSWC_MODE_PD_HIZ = 2'h3
  } dswc_mode_t;

  function automatic logic dswc_is_pd(input logic [1:0] mode);
    return mode != DSWC_MODE_NORMAL;
  endfunction : dswc_is_pd
endpackage : dswc_pkg

// file: dswc_if.sv
// three-wire serial write link between host and converter
`timescale 1ns/10ps
interface dswc_if;
  logic sync_n;
  logic sclk;
  logic sdata;
  modport host (output sync_n, output sclk, output sdata);
  modport dev  (input sync_n, input sclk, input sdata);
endinterface : dswc_if

// file: dswc_host.sv
// host end: sends one 16-bit word per request over the serial link
`timescale 1ns/10ps
module dswc_host
  import dswc_pkg::*;
(
  input  wire logic        clk_sys_i,     // system clock
  input  wire logic        rstn_i,        // sync reset, low
  dswc_if.host             link,          // serial pins
  input  wire logic        req_i,         // start write, level sampled when ready
  input  wire logic [1:0]  req_mode_i,    // power mode to send
  input  wire logic [11:0] req_code_i,    // code to send
  input  wire logic        abort_i,       // raise frame early, discarding word
  output logic             ready_o,       // idle, request accepted
  output logic             done_o         // pulse: word fully sent
);
  typedef enum logic [1:0] {S_IDLE, S_GAP, S_SHIFT} dswc_hstate_t;
  dswc_hstate_t state_reg;
  logic [15:0]  word_reg;
  logic [4:0]   bits_reg;
  logic [3:0]   tmr_reg;

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      state_reg   <= S_IDLE;
      word_reg    <= 16'h0000;
      bits_reg    <= 5'h00;
      tmr_reg     <= 4'h0;
      link.sync_n <= 1'b0; // parked low for low power
      link.sclk   <= 1'b1;
      link.sdata  <= 1'b0;
      ready_o     <= 1'b1;
      done_o      <= 1'b0;
    end else begin
      done_o <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (req_i) begin
            word_reg    <= {2'h0, req_mode_i, req_code_i};
            link.sync_n <= 1'b1;
            tmr_reg     <= SYNC_HIGH_CNT;
            ready_o     <= 1'b0;
            state_reg   <= S_GAP;
          end
        end
        S_GAP: begin
          if (tmr_reg == 4'h1) begin
            link.sync_n <= 1'b0;
            link.sdata  <= word_reg[15];
            word_reg    <= {word_reg[14:0], 1'b0};
            bits_reg    <= 5'h00;
            tmr_reg     <= SCLK_HALF_CNT;
            state_reg   <= S_SHIFT;
          end else begin
            tmr_reg <= tmr_reg - 4'h1;
          end
        end
        S_SHIFT: begin
          if (abort_i) begin
            link.sync_n <= 1'b1; // early rise discards word
            link.sclk   <= 1'b1;
            tmr_reg     <= SYNC_HIGH_CNT;
            state_reg   <= S_IDLE;
            ready_o     <= 1'b1;
          end else if (tmr_reg != 4'h1) begin
            tmr_reg <= tmr_reg - 4'h1;
          end else begin
            tmr_reg <= SCLK_HALF_CNT;
            if (link.sclk) begin
              link.sclk <= 1'b0;
              bits_reg  <= bits_reg + 5'h01;
            end else if (bits_reg == LAST_BIT_CNT) begin
              link.sclk <= 1'b1; // frame left low after the word
              done_o    <= 1'b1;
              ready_o   <= 1'b1;
              state_reg <= S_IDLE;
            end else begin
              link.sclk  <= 1'b1;
              link.sdata <= word_reg[15];
              word_reg   <= {word_reg[14:0], 1'b0};
            end
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule : dswc_host

// file: dswc_checker.sv
// protocol checks on the shared serial link pins
`timescale 1ns/10ps
module dswc_checker (
  input  wire logic clk_sys_i, // system clock
  input  wire logic rstn_i,    // sync reset, low
  input  wire logic sync_n,    // frame select, low
  input  wire logic sclk,      // serial clock
  input  wire logic sdata      // serial data
);
  logic [4:0] fall_cnt_reg;    // sclk falls seen in this frame
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i || sync_n) fall_cnt_reg <= 5'h00;
    else if ($fell(sclk)) fall_cnt_reg <= fall_cnt_reg + 5'h01;
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  a_gap_min: assert property ($rose(sync_n) |-> sync_n [*4])
    else $error("frame gap too short");
  a_sclk_idle: assert property (sync_n |-> sclk)
    else $error("sclk low outside frame");
  a_low_len: assert property ($fell(sclk) |=> !sclk || sync_n)
    else $error("sclk low phase too short");
  a_high_len: assert property ($rose(sclk) && !sync_n |=> sclk || sync_n)
    else $error("sclk high phase too short");
  a_data_hold: assert property (!sclk && !$past(sclk) |-> $stable(sdata))
    else $error("sdata moved while sclk low");
  a_sync_setup: assert property ($fell(sync_n) |-> sclk [*2])
    else $error("sclk fell too soon after frame start");
  a_sixteen_max: assert property ($fell(sclk) |-> fall_cnt_reg < 5'h10)
    else $error("more than sixteen bits in frame");
  a_idle_frozen: assert property (sync_n && $past(sync_n) |-> $stable(sclk))
    else $error("sclk moved between frames");
  cover property ($fell(sclk) && fall_cnt_reg == 5'h0f);
  cover property ($rose(sync_n) && fall_cnt_reg != 5'h00 && fall_cnt_reg < 5'h10);
  cover property ($fell(sync_n));
endmodule : dswc_checker

// file: test_dac_serial_write_control.sv
// bench: host and converter ends on one link, a second converter on a hand-driven link
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; \
  $display("[ERR] %0t got %h want %h", $time, a, b); end end
module test_dac_serial_write_control;
  import dswc_pkg::*;
  logic        clk_sys_i  = 1'b0;
  logic        rstn_i     = 1'b0;
  logic        req_i      = 1'b0;
  logic [1:0]  req_mode_i = 2'h0;
  logic [11:0] req_code_i = 12'h000;
  logic        abort_i    = 1'b0;
  logic        ready_o, done_o, update_o, amp_on_o, term_1k_o, term_100k_o;
  logic [11:0] code_o, code2;
  logic [1:0]  mode_o, mode2;
  logic [17:0] word2      = {16'h2abc, 2'h3}; // two extra bits after the word
  logic [16:0] rows [4]   = '{{2'h0, 12'hfff, 3'h4}, {2'h1, 12'h001, 3'h2},
                              {2'h2, 12'h800, 3'h1}, {2'h3, 12'h5a5, 3'h0}};
  int          fails = 0, comparisons = 0, updates = 0, dones = 0;
  dswc_if lk ();
  dswc_if lk2 ();
  dswc_host u_dswc_host (.clk_sys_i, .rstn_i, .link(lk.host), .req_i, .req_mode_i,
    .req_code_i, .abort_i, .ready_o, .done_o);
  dswc_dev u_dswc_dev (.clk_sys_i, .rstn_i, .link(lk.dev), .code_o, .mode_o, .amp_on_o,
    .term_1k_o, .term_100k_o, .update_o);
  dswc_dev u_dswc_dev_b (.clk_sys_i, .rstn_i, .link(lk2.dev), .code_o(code2),
    .mode_o(mode2), .amp_on_o(), .term_1k_o(), .term_100k_o(), .update_o());
  dswc_checker u_dswc_checker (.clk_sys_i, .rstn_i, .sync_n(lk.sync_n), .sclk(lk.sclk),
    .sdata(lk.sdata));
  always #5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) if (update_o === 1'b1) updates++;
  always @(posedge clk_sys_i) if (done_o === 1'b1) dones++;
  task results;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  task wait_ready;
    for (int k = 0; k < 200 && ready_o !== 1'b1; k++) @(negedge clk_sys_i);
    repeat (8) @(negedge clk_sys_i);
  endtask : wait_ready
  task start(input logic [1:0] m, input logic [11:0] c);
    @(negedge clk_sys_i) {req_i, req_mode_i, req_code_i} = {1'b1, m, c};
    @(negedge clk_sys_i) req_i = 1'b0;
  endtask : start
  // link clock at 125 ns, unrelated in phase to the system clock
  task bit2(input logic b);
    lk2.sdata = b;
    #62.5 lk2.sclk = 1'b0;
    #62.5 lk2.sclk = 1'b1;
  endtask : bit2
  initial begin
    {lk2.sync_n, lk2.sclk, lk2.sdata} = 3'b110;
    repeat (3) @(negedge clk_sys_i);
    rstn_i = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    `CHK(code_o, CODE_RESET)
    `CHK(mode_o, MODE_RESET)
    `CHK(amp_on_o, 1'b1)
    for (int i = 0; i < 4; i++) begin
      start(rows[i][16:15], rows[i][14:3]);
      wait_ready();
      `CHK(code_o, rows[i][14:3])
      `CHK(mode_o, rows[i][16:15])
      `CHK({amp_on_o, term_1k_o, term_100k_o}, rows[i][2:0])
      `CHK(updates, i + 1)
      `CHK(dones, i + 1)
      `CHK(lk.sync_n, 1'b0)
    end
    start(2'h0, 12'h123);
    repeat (30) @(negedge clk_sys_i);
    abort_i = 1'b1;
    @(negedge clk_sys_i) abort_i = 1'b0;
    wait_ready();
    `CHK(code_o, 12'h5a5)
    `CHK(mode_o, 2'h3)
    `CHK(updates, 4)
    `CHK(dones, 4)
    start(2'h0, 12'h3c3);
    wait_ready();
    `CHK(code_o, 12'h3c3)
    `CHK(dones, 5)
    repeat (250) @(negedge clk_sys_i);
    `CHK({amp_on_o, term_1k_o, term_100k_o}, 3'h4)
    repeat (3) bit2(1'b0);
    `CHK(code2, CODE_RESET)
    #62.5 lk2.sync_n = 1'b0;
    for (int j = 17; j >= 0; j--) bit2(word2[j]);
    #200;
    `CHK(code2, 12'habc)
    `CHK(mode2, 2'h2)
    #62.5 lk2.sync_n = 1'b1;
    #200;
    `CHK(code2, 12'habc)
    @(negedge clk_sys_i) rstn_i = 1'b0;
    repeat (3) @(negedge clk_sys_i);
    `CHK({code_o, mode_o, code2, mode2}, 28'h0000000)
    rstn_i = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    `CHK({amp_on_o, term_1k_o, term_100k_o}, 3'h4)
    start(2'h1, 12'h0f0);
    wait_ready();
    `CHK(code_o, 12'h0f0)
    `CHK(mode_o, 2'h1)
    results();
  end
  initial begin
    #100000;
    fails++;
    results();
  end
endmodule : test_dac_serial_write_control
